// >>> core/vtl_ctrl.sv
// Purpose: transport-layer control: access, heartbeat, discovery, messages, stream pacing
// Assumes: host and stream inputs come from logic on the same clock
// Notes:   gaps counted in 8 ns units, five units per clock
`timescale 1ns/10ps
module vtl_ctrl
    import vtl_pkg::*;
#(
    parameter int          CYC_MS   = CYC_PER_MS,
    parameter logic [15:0] MC_COUNT = 16'h0001,
    parameter logic [15:0] SC_COUNT = 16'h0001,
    parameter logic [15:0] MCSP     = 16'h1000, // arbitrary
    parameter logic [15:0] SCSP     = 16'h1001  // arbitrary
)
(
    // clock and reset
    input  wire logic            clock,
    input  wire logic            rst,
    // register port
    input  wire vtl_reg_req_t    reg_req,
    output logic [31:0]          reg_rdata,
    // host control commands
    input  wire vtl_host_req_t   host_req,
    output logic                 host_accept,
    output logic                 host_write_ok,
    output logic                 host_primary,
    // discovery
    input  wire logic            disc_req,
    output logic                 disc_ack,
    // message channel
    input  wire logic            msg_req,
    input  wire logic            msg_ack,
    output logic                 msg_send,
    output logic                 msg_fail,
    output vtl_dest_t            msg_dest,
    // stream channel
    input  wire logic            frame_req,
    input  wire logic            pkt_done,
    input  wire logic            frame_end,
    output logic                 pkt_ok,
    output logic                 test_pkt,
    input  wire logic [15:0]     pix_in,
    output logic [15:0]          pix_out,
    output vtl_stream_cfg_t      stream_cfg,
    // ip configuration
    output logic [2:0]           ip_cfg
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {M_IDLE, M_WAIT} vtl_msg_st_t;
    typedef enum logic [1:0] {G_IDLE, G_FGAP, G_RUN, G_PGAP} vtl_gap_st_t;
    typedef struct packed {
        logic [31:0] hb_to;
        logic        hb_dis;
        logic [31:0] hb_cnt;
        vtl_ccp_t    mode;
        logic        prim_v;
        vtl_dest_t   prim;
        logic [31:0] ms_cnt;
        logic [9:0]  disc_max;
        logic [9:0]  lfsr;
        logic        disc_busy;
        logic [9:0]  disc_tgt;
        logic [9:0]  disc_cnt;
        logic        disc_ack;
        vtl_dest_t   mc;
        logic [31:0] mctt;
        logic [31:0] mcrc;
        vtl_msg_st_t mst;
        logic [31:0] tmo;
        logic [31:0] tries;
        logic        send;
        logic        fail;
        vtl_dest_t   sc;
        logic [2:0]  flags;
        logic        test;
        logic [15:0] pkt_sz;
        logic [31:0] scpd;
        logic [31:0] fgap;
        vtl_gap_st_t gst;
        logic [31:0] rem;
        logic [15:0] pix;
        logic [2:0]  ipcfg;
        logic [31:0] rdata;
    } vtl_state_t;
    vtl_state_t s_q;
    vtl_state_t s_d;

    logic [63:0] ts_val;
    logic        ts_latch;
    logic        ts_clear;
    logic        ms_tick;
    logic        match;
    logic [20:0] prod;

    assign ts_latch = reg_req.wr && reg_req.addr == A_TSCTL && reg_req.wdata[TS_LATCH_BIT];
    assign ts_clear = reg_req.wr && reg_req.addr == A_TSCTL && reg_req.wdata[TS_CLEAR_BIT];
    assign ms_tick  = s_q.ms_cnt == 32'(CYC_MS - 1);
    assign match    = s_q.prim_v && host_req.ip == s_q.prim.ip && host_req.port == s_q.prim.port;
    assign prod     = 21'(s_q.lfsr) * (21'(s_q.disc_max) + 21'h1);

    vtl_timestamp u_ts (
        .clock (clock),
        .rst   (rst),
        .latch (ts_latch),
        .clear (ts_clear),
        .value (ts_val)
    );

    // ------------------------------------------------------------
    // access privilege
    // ------------------------------------------------------------
    always_comb begin
        case (s_q.mode)
            VTL_OPEN: begin
                host_accept   = 1'b1;
                host_write_ok = 1'b0;
            end
            VTL_EXCL: begin
                host_accept   = match || !s_q.prim_v;
                host_write_ok = match || !s_q.prim_v;
            end
            VTL_CTRL: begin
                host_accept   = 1'b1;
                host_write_ok = match || !s_q.prim_v;
            end
            default: begin
                host_accept   = 1'b0;
                host_write_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.disc_ack = 1'b0;
        s_d.send = 1'b0;
        s_d.fail = 1'b0;
        s_d.test = 1'b0;
        s_d.ms_cnt = ms_tick ? 32'h0 : s_q.ms_cnt + 32'h1;
        s_d.lfsr = {s_q.lfsr[8:0], s_q.lfsr[9] ^ s_q.lfsr[6]};
        // primary claim and heartbeat
        if (s_q.mode == VTL_OPEN) begin
            s_d.prim_v = 1'b0;
        end else if (host_req.valid && !s_q.prim_v) begin
            s_d.prim_v = 1'b1;
            s_d.prim = {host_req.ip, host_req.port};
            s_d.hb_cnt = 32'h0;
        end else if (host_req.valid && match) begin
            s_d.hb_cnt = 32'h0;
        end else if (s_q.prim_v && !s_q.hb_dis && ms_tick) begin
            s_d.hb_cnt = s_q.hb_cnt + 32'h1;
            if (s_q.hb_cnt + 32'h1 >= s_q.hb_to) begin
                s_d.prim_v = 1'b0;
            end
        end
        // discovery acknowledge delay
        if (!s_q.disc_busy && disc_req) begin
            s_d.disc_busy = 1'b1;
            s_d.disc_tgt = prod[19:10];
            s_d.disc_cnt = 10'h0;
        end else if (s_q.disc_busy) begin
            if (s_q.disc_cnt >= s_q.disc_tgt) begin
                s_d.disc_busy = 1'b0;
                s_d.disc_ack = 1'b1;
            end else if (ms_tick) begin
                s_d.disc_cnt = s_q.disc_cnt + 10'h1;
            end
        end
        // message channel
        case (s_q.mst)
            M_IDLE: begin
                if (msg_req) begin
                    s_d.mst = M_WAIT;
                    s_d.send = 1'b1;
                    s_d.tmo = 32'h0;
                    s_d.tries = 32'h0;
                end
            end
            M_WAIT: begin
                if (msg_ack) begin
                    s_d.mst = M_IDLE;
                end else if (ms_tick) begin
                    s_d.tmo = s_q.tmo + 32'h1;
                    if (s_q.tmo + 32'h1 >= s_q.mctt) begin
                        s_d.tmo = 32'h0;
                        if (s_q.tries < s_q.mcrc) begin
                            s_d.tries = s_q.tries + 32'h1;
                            s_d.send = 1'b1;
                        end else begin
                            s_d.fail = 1'b1;
                            s_d.mst = M_IDLE;
                        end
                    end
                end
            end
            default: s_d.mst = M_IDLE;
        endcase
        // stream pacing
        case (s_q.gst)
            G_IDLE: begin
                if (frame_req) begin
                    s_d.gst = G_FGAP;
                    s_d.rem = s_q.fgap;
                end
            end
            G_FGAP, G_PGAP: begin
                if (s_q.rem <= GAP_STEP) begin
                    s_d.gst = G_RUN;
                    s_d.rem = 32'h0;
                end else begin
                    s_d.rem = s_q.rem - GAP_STEP;
                end
            end
            G_RUN: begin
                if (frame_end) begin
                    s_d.gst = G_IDLE;
                end else if (pkt_done) begin
                    s_d.gst = G_PGAP;
                    s_d.rem = s_q.scpd;
                end
            end
            default: s_d.gst = G_IDLE;
        endcase
        s_d.pix = s_q.flags[F_BIG] ? {pix_in[7:0], pix_in[15:8]} : pix_in;
        // register writes
        if (reg_req.wr) begin
            case (reg_req.addr)
                A_HB:     s_d.hb_to = reg_req.wdata;
                A_DISC:   s_d.disc_max = reg_req.wdata > 32'(DISC_MAX) ? DISC_MAX : reg_req.wdata[9:0];
                A_HBDIS:  s_d.hb_dis = reg_req.wdata[0];
                A_CCP:    s_d.mode = reg_req.wdata[1:0] > 2'h2 ? VTL_EXCL : vtl_ccp_t'(reg_req.wdata[1:0]);
                A_MCPORT: s_d.mc.port = reg_req.wdata[15:0];
                A_MCDA:   s_d.mc.ip = reg_req.wdata;
                A_MCTT:   s_d.mctt = reg_req.wdata;
                A_MCRC:   s_d.mcrc = reg_req.wdata;
                A_SCPORT: s_d.sc.port = reg_req.wdata[15:0];
                A_SCDA:   s_d.sc.ip = reg_req.wdata;
                A_SCFLAG: begin
                    s_d.flags = reg_req.wdata[2:0];
                    s_d.test = reg_req.wdata[F_TEST] && !s_q.flags[F_TEST];
                end
                A_PKTSZ: begin
                    if (reg_req.wdata < 32'(PKT_MIN)) begin
                        s_d.pkt_sz = PKT_MIN;
                    end else if (reg_req.wdata > 32'(PKT_MAX)) begin
                        s_d.pkt_sz = PKT_MAX;
                    end else begin
                        s_d.pkt_sz = reg_req.wdata[15:0];
                    end
                end
                A_SCPD:   s_d.scpd = reg_req.wdata & SCPD_MAX;
                A_FGAP:   s_d.fgap = reg_req.wdata > FGAP_MAX ? FGAP_MAX : reg_req.wdata;
                A_IPCFG:  s_d.ipcfg = reg_req.wdata[2:0];
                default:  s_d.rdata = s_d.rdata;
            endcase
        end
        // register reads
        s_d.rdata = 32'h0;
        if (reg_req.rd) begin
            case (reg_req.addr)
                A_HB:     s_d.rdata = s_q.hb_to;
                A_DISC:   s_d.rdata = 32'(s_q.disc_max);
                A_HBDIS:  s_d.rdata = 32'(s_q.hb_dis);
                A_CCP:    s_d.rdata = 32'(s_q.mode);
                A_PAPORT: s_d.rdata = s_q.prim_v ? 32'(s_q.prim.port) : 32'h0;
                A_PAIP:   s_d.rdata = s_q.prim_v ? s_q.prim.ip : 32'h0;
                A_MCPORT: s_d.rdata = 32'(s_q.mc.port);
                A_MCDA:   s_d.rdata = s_q.mc.ip;
                A_MCTT:   s_d.rdata = s_q.mctt;
                A_MCRC:   s_d.rdata = s_q.mcrc;
                A_MCSP:   s_d.rdata = 32'(MCSP);
                A_TSFREQ: s_d.rdata = 32'(TS_FREQ_HZ);
                A_TSLO:   s_d.rdata = ts_val[31:0];
                A_TSHI:   s_d.rdata = ts_val[63:32];
                A_SCPORT: s_d.rdata = 32'(s_q.sc.port);
                A_SCFLAG: s_d.rdata = 32'(s_q.flags);
                A_PKTSZ:  s_d.rdata = 32'(s_q.pkt_sz);
                A_SCPD:   s_d.rdata = s_q.scpd;
                A_FGAP:   s_d.rdata = s_q.fgap;
                A_SCDA:   s_d.rdata = s_q.sc.ip;
                A_SCSP:   s_d.rdata = 32'(SCSP);
                A_CHCNT:  s_d.rdata = {SC_COUNT, MC_COUNT};
                A_IPCFG:  s_d.rdata = 32'(s_q.ipcfg);
                default:  s_d.rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.hb_to <= HB_DEF;
            s_q.mode <= VTL_EXCL;
            s_q.disc_max <= DISC_DEF;
            s_q.lfsr <= 10'h001;
            s_q.mctt <= MCTT_DEF;
            s_q.mcrc <= MCRC_DEF;
            s_q.pkt_sz <= PKT_DEF;
            s_q.ipcfg <= IPCFG_DEF;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    assign host_primary = s_q.prim_v;
    assign disc_ack = s_q.disc_ack;
    assign msg_send = s_q.send;
    assign msg_fail = s_q.fail;
    assign msg_dest = s_q.mc;
    assign pkt_ok = s_q.gst == G_RUN;
    assign test_pkt = s_q.test;
    assign pix_out = s_q.pix;
    assign stream_cfg = {s_q.flags[F_DNF], s_q.flags[F_BIG], s_q.pkt_sz, s_q.sc};
    assign ip_cfg = s_q.ipcfg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_hb_release: assert property (s_q.prim_v && !s_q.hb_dis && ms_tick && !host_req.valid
        && s_q.hb_cnt + 32'h1 >= s_q.hb_to && s_q.mode != VTL_OPEN |=> !host_primary) else $error("no release");
    a_hb_disabled: assert property (s_q.hb_dis && host_primary && s_q.mode != VTL_OPEN
        |=> host_primary) else $error("released while disabled");
    a_open_no_write: assert property (s_q.mode == VTL_OPEN |-> !host_write_ok) else $error("open write");
    a_excl_reject: assert property (s_q.mode == VTL_EXCL && host_primary && !match
        |-> !host_accept) else $error("other host let in");
    a_ctrl_monitor: assert property (s_q.mode == VTL_CTRL && host_primary && !match
        |-> host_accept && !host_write_ok) else $error("secondary wrong");
    a_disc_bound: assert property (s_q.disc_busy |-> s_q.disc_tgt <= s_q.disc_max
        && s_q.disc_max <= DISC_MAX) else $error("disc over max");
    a_msg_retry: assert property (msg_fail |-> s_q.tries == s_q.mcrc) else $error("retries wrong");
    a_test_pulse: assert property (test_pkt |=> !test_pkt) else $error("test not one pulse");
    a_pkt_range: assert property (s_q.pkt_sz >= PKT_MIN && s_q.pkt_sz <= PKT_MAX) else $error("pkt size");
    a_frame_gap: assert property (s_q.gst == G_IDLE && frame_req && s_q.fgap > GAP_STEP
        |=> !pkt_ok ##1 !pkt_ok) else $error("frame gap skipped");
    c_msg_fail: cover property (msg_fail);
    c_disc_ack: cover property (disc_req ##[1:50] disc_ack);
    c_pkt_gap: cover property (pkt_ok && pkt_done ##1 !pkt_ok ##[1:20] pkt_ok);
    c_claim: cover property (!host_primary ##1 host_primary);
endmodule

// >>> core/vtl_pkg.sv
// Purpose: constants, offsets and carriers for transport-layer control
// Assumes: one 25 MHz clock, register port with read data one cycle later
// Notes:   all offsets are byte addresses on the local register port
// What this block does
// - heartbeat timeout in ms, writable, default 3000, full 32-bit range.
// - latch command copies running timestamp into readable value register.
// - reset command clears running timestamp to zero; counting continues.
// - timestamp value reads latched 64-bit contents, not the live count.
// - tick frequency in hertz is readable.
// - discovery ack delayed randomly up to max, default 50 ms, range 0..1000.
// - heartbeat disable flag true stops supervision; false keeps it active.
// - open access lets hosts read and watch but refuses their writes.
// - exclusive access, the default, gives primary control and rejects others.
// - control access gives primary control; others only read and watch.
// - primary application port and IP address are readable.
// - messages go to programmable port and IP; own source port readable.
// - message ack timeout programmable, default 300 ms.
// - unacknowledged message resent up to retry count, default 2.
// - test-packet flag active emits one test packet on the stream.
// - do-not-fragment option sets the stream packets' IP header bit.
// - pixel data big-endian when flag true, little-endian when false.
// - packet size 72..16364 bytes, default 1500.
// - inter-packet gap in 8 ns units, 0 default, up to 0xFFFFFFF.
// - gap before each frame in 8 ns units, 0 default, up to 0xFFFFE795.
// - channel counts readable; stream goes to programmable IP and port.
// - each IP configuration method has its own active flag.
package vtl_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS      = 40;
    localparam int TS_FREQ_HZ  = 1_000_000_000 / CLK_NS;
    localparam int MS_NS       = 1_000_000;
    localparam int CYC_PER_MS  = MS_NS / CLK_NS;
    localparam int GAP_UNIT_NS = 8;
    localparam logic [31:0] GAP_STEP = 32'(CLK_NS / GAP_UNIT_NS);
    // ------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------
    localparam logic [31:0] HB_DEF   = 32'h0000_0bb8;
    localparam logic [9:0]  DISC_DEF = 10'h032;
    localparam logic [9:0]  DISC_MAX = 10'h3e8;
    localparam logic [31:0] MCTT_DEF = 32'h0000_012c;
    localparam logic [31:0] MCRC_DEF = 32'h0000_0002;
    localparam logic [15:0] PKT_DEF  = 16'h05dc;
    localparam logic [15:0] PKT_MIN  = 16'h0048;
    localparam logic [15:0] PKT_MAX  = 16'h3fec;
    localparam logic [31:0] SCPD_MAX = 32'h0fff_ffff;
    localparam logic [31:0] FGAP_MAX = 32'hffff_e795;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_HB     = 8'h00;
    localparam logic [7:0] A_DISC   = 8'h04;
    localparam logic [7:0] A_HBDIS  = 8'h08;
    localparam logic [7:0] A_CCP    = 8'h0c;
    localparam logic [7:0] A_PAPORT = 8'h10;
    localparam logic [7:0] A_PAIP   = 8'h14;
    localparam logic [7:0] A_MCPORT = 8'h18;
    localparam logic [7:0] A_MCDA   = 8'h1c;
    localparam logic [7:0] A_MCTT   = 8'h20;
    localparam logic [7:0] A_MCRC   = 8'h24;
    localparam logic [7:0] A_MCSP   = 8'h28;
    localparam logic [7:0] A_TSFREQ = 8'h2c;
    localparam logic [7:0] A_TSCTL  = 8'h30;
    localparam logic [7:0] A_TSLO   = 8'h34;
    localparam logic [7:0] A_TSHI   = 8'h38;
    localparam logic [7:0] A_SCPORT = 8'h3c;
    localparam logic [7:0] A_SCFLAG = 8'h40;
    localparam logic [7:0] A_PKTSZ  = 8'h44;
    localparam logic [7:0] A_SCPD   = 8'h48;
    localparam logic [7:0] A_FGAP   = 8'h4c;
    localparam logic [7:0] A_SCDA   = 8'h50;
    localparam logic [7:0] A_SCSP   = 8'h54;
    localparam logic [7:0] A_CHCNT  = 8'h58;
    localparam logic [7:0] A_IPCFG  = 8'h5c;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TS_LATCH_BIT = 0;
    localparam int TS_CLEAR_BIT = 1;
    localparam int F_TEST       = 0;
    localparam int F_DNF        = 1;
    localparam int F_BIG        = 2;
    localparam int CH_SC_LSB    = 16;
    localparam logic [2:0] IPCFG_DEF = 3'h7;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VTL_OPEN = 2'h0,
        VTL_EXCL = 2'h1,
        VTL_CTRL = 2'h2
    } vtl_ccp_t;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } vtl_reg_req_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] ip;
        logic [15:0] port;
    } vtl_host_req_t;
    typedef struct packed {
        logic [31:0] ip;
        logic [15:0] port;
    } vtl_dest_t;
    typedef struct packed {
        logic        dnf;
        logic        big_endian;
        logic [15:0] pkt_size;
        vtl_dest_t   dest;
    } vtl_stream_cfg_t;
endpackage

// >>> core/vtl_timestamp.sv
// Purpose: free-running 64-bit timestamp with latch and clear
// Assumes: one tick per clock
// Notes:   latch and clear in one cycle latch the old count
`timescale 1ns/10ps
module vtl_timestamp
    import vtl_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // commands
    input  wire logic        latch,
    input  wire logic        clear,
    // latched value
    output logic [63:0]      value
);
    typedef struct packed {
        logic [63:0] cnt;
        logic [63:0] val;
    } vtl_ts_state_t;
    vtl_ts_state_t s_q;
    vtl_ts_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.cnt = s_q.cnt + 64'h1;
        if (clear) begin
            s_d.cnt = 64'h0;
        end
        if (latch) begin
            s_d.val = s_q.cnt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign value = s_q.val;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_ts_latch_copy: assert property (latch |=> value == $past(s_q.cnt)) else $error("latch lost count");
    a_ts_clear_zero: assert property (clear |=> s_q.cnt == 64'h0 ##1
        s_q.cnt == ($past(clear) ? 64'h0 : 64'h1)) else $error("clear bad");
    a_ts_tick_step: assert property (!clear && !$past(rst) |=>
        s_q.cnt == $past(s_q.cnt) + 64'h1) else $error("tick skipped");
endmodule

// >>> testbench/vtl_host_model.sv
// Purpose: message host that acknowledges sends
// Assumes: same clock as the device
// Notes:   ack_en low leaves every send unanswered
`timescale 1ns/10ps
module vtl_host_model (
    // clock
    input  wire logic clock,
    // message channel
    input  wire logic ack_en,
    input  wire logic msg_send,
    output logic      msg_ack
);
    logic [2:0] d_q = 3'h0;
    always @(posedge clock) d_q <= {d_q[1:0], msg_send & ack_en};
    assign msg_ack = d_q[2];
endmodule

// >>> testbench/vtl_ctrl_tb.sv
// Purpose: register-level bench for transport-layer control
// Assumes: one ms shortened to 10 cycles
// Notes:   host commands driven here, message acks by the model
`timescale 1ns/10ps
module vtl_ctrl_tb
    import vtl_pkg::*;
;
    // ------------------------------------------------------------
    // signals and tables
    // ------------------------------------------------------------
    logic            clock = 1'b0, rst = 1'b1, mreq = 1'b0, freq = 1'b0, pdone = 1'b0, fend = 1'b0, ack_en = 1'b0;
    vtl_reg_req_t    rq = '0;
    vtl_host_req_t   hq = '0;
    logic [15:0]     pix = 16'h0, pixo;
    logic [31:0]     rdata, v1;
    logic            acc, wok, prim, mack, msend, mfail, pok, tpk, dack, dreq = 1'b0;
    vtl_dest_t       mdest;
    vtl_stream_cfg_t scfg;
    logic [2:0]      ipc;
    int              fails = 0, comparisons = 0, i, n, s, f;
    logic [7:0]      ta[14] = '{A_HB, A_DISC, A_CCP, A_MCTT, A_MCRC, A_PKTSZ, A_TSFREQ, A_CHCNT,
                                A_PKTSZ, A_PKTSZ, A_DISC, A_SCPD, A_FGAP, A_HB};
    logic [31:0]     tw[14] = '{0, 0, 0, 0, 0, 0, 0, 0, 32'h10, 32'hffff, 32'h7d0, '1, '1, '1};
    logic [31:0]     te[14] = '{HB_DEF, 32'(DISC_DEF), 32'h1, MCTT_DEF, MCRC_DEF, 32'(PKT_DEF), 32'(TS_FREQ_HZ),
                                32'h0001_0001, 32'h48, 32'h3fec, 32'h3e8, SCPD_MAX, FGAP_MAX, '1};
    vtl_ctrl #(.CYC_MS(10)) u_vtl_ctrl (.clock(clock), .rst(rst), .reg_req(rq), .reg_rdata(rdata),
        .host_req(hq), .host_accept(acc), .host_write_ok(wok), .host_primary(prim), .disc_req(dreq),
        .disc_ack(dack), .msg_req(mreq), .msg_ack(mack), .msg_send(msend), .msg_fail(mfail), .msg_dest(mdest),
        .frame_req(freq), .pkt_done(pdone), .frame_end(fend), .pkt_ok(pok), .test_pkt(tpk), .pix_in(pix),
        .pix_out(pixo), .stream_cfg(scfg), .ip_cfg(ipc));
    vtl_host_model u_vtl_host_model (.clock(clock), .ack_en(ack_en), .msg_send(msend), .msg_ack(mack));
    initial forever #20 clock = ~clock;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task final_report;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock) rq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock) rq <= '0;
        #1;
    endtask
    task rdq(input logic [7:0] a);
        @(posedge clock) rq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock) rq <= '0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        rdq(a);
        chk("rdata", e, rdata);
    endtask
    task host(input logic [31:0] ip, input logic v);
        @(posedge clock) hq <= '{v, ip, 16'h1234};
        @(posedge clock) hq.valid <= 1'b0;
        #1;
    endtask
    task automatic wt(ref logic sg, input logic l, input int lim, output int c);
        for (c = 0; c < lim && sg !== l; c++) @(posedge clock) #1;
        if (c == lim) begin
            fails++;
            $display("MISMATCH wait exp %h got %h", l, sg);
            final_report;
        end
    endtask
    task msg_run;
        @(posedge clock) mreq <= 1'b1;
        @(posedge clock) mreq <= 1'b0;
        s = 0;
        f = 0;
        repeat (60) begin
            #1 s += int'(msend);
            f += int'(mfail);
            @(posedge clock);
        end
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 14; i++) begin
            if (i > 7) wr(ta[i], tw[i]);
            rd(ta[i], te[i]);
        end
        wr(A_TSCTL, 32'h1);
        rdq(A_TSLO);
        v1 = rdata;
        wr(A_TSCTL, 32'h1);
        rd(A_TSLO, v1 + 32'h4);
        rd(A_TSLO, v1 + 32'h4);
        wr(A_TSCTL, 32'h2);
        wr(A_TSCTL, 32'h1);
        rd(A_TSHI, 32'h0);
        rdq(A_TSLO);
        chk("ts_clear", 32'h1, 32'(rdata < 32'h8));
        host(32'h0a00_0001, 1'b1);
        chk("primary", 32'h1, 32'(prim));
        chk("write_ok", 32'h1, 32'(wok));
        host(32'h0a00_0002, 1'b0);
        chk("accept", 32'h0, 32'(acc));
        rd(A_PAIP, 32'h0a00_0001);
        wr(A_CCP, 32'h2);
        host(32'h0a00_0002, 1'b0);
        chk("accept", 32'h1, 32'(acc));
        chk("write_ok", 32'h0, 32'(wok));
        wr(A_CCP, 32'h0);
        host(32'h0a00_0001, 1'b0);
        chk("accept", 32'h1, 32'(acc));
        chk("write_ok", 32'h0, 32'(wok));
        wr(A_CCP, 32'h1);
        wr(A_HB, 32'h2);
        wr(A_HBDIS, 32'h1);
        host(32'h0a00_0001, 1'b1);
        repeat (100) @(posedge clock);
        chk("primary", 32'h1, 32'(prim));
        wr(A_HBDIS, 32'h0);
        wt(prim, 1'b0, 40, n);
        wr(A_MCTT, 32'h1);
        wr(A_MCDA, 32'hc0a8_0002);
        wr(A_MCPORT, 32'h2345);
        chk("msg_dest", 32'hc0a8_0002, mdest.ip);
        chk("msg_port", 32'h2345, 32'(mdest.port));
        msg_run;
        chk("sends", 32'h3, 32'(s));
        chk("fail", 32'h1, 32'(f));
        ack_en <= 1'b1;
        wr(A_MCTT, 32'h2);
        msg_run;
        chk("sends", 32'h1, 32'(s));
        chk("fail", 32'h0, 32'(f));
        wr(A_SCFLAG, 32'h6);
        @(posedge clock) pix <= 16'h1234;
        @(posedge clock) #1;
        chk("pix", 32'h3412, 32'(pixo));
        chk("dnf", 32'h1, 32'(scfg.dnf));
        chk("big", 32'h1, 32'(scfg.big_endian));
        wr(A_SCFLAG, 32'h0);
        @(posedge clock) #1;
        chk("pix", 32'h1234, 32'(pixo));
        chk("dnf", 32'h0, 32'(scfg.dnf));
        wr(A_SCFLAG, 32'h1);
        wt(tpk, 1'b1, 4, n);
        wr(A_FGAP, 32'h32);
        wr(A_SCPD, 32'h19);
        @(posedge clock) freq <= 1'b1;
        @(posedge clock) freq <= 1'b0;
        wt(pok, 1'b1, 20, n);
        chk("frame_gap", 32'h1, 32'(n >= 7 && n <= 11));
        @(posedge clock) pdone <= 1'b1;
        @(posedge clock) pdone <= 1'b0;
        #1 wt(pok, 1'b1, 20, n);
        chk("pkt_gap", 32'h1, 32'(n >= 2 && n <= 6));
        wr(A_IPCFG, 32'h5);
        chk("ip_cfg", 32'h5, 32'(ipc));
        @(posedge clock) fend <= 1'b1;
        @(posedge clock) fend <= 1'b0;
        #1 chk("frame_end", 32'h0, 32'(pok));
        wr(A_PKTSZ, 32'h5dc);
        chk("pkt_size", 32'h5dc, 32'(scfg.pkt_size));
        wr(A_SCDA, 32'hc0a8_0003);
        chk("sc_ip", 32'hc0a8_0003, scfg.dest.ip);
        wr(A_DISC, 32'h1);
        @(posedge clock) dreq <= 1'b1;
        @(posedge clock) dreq <= 1'b0;
        #1 wt(dack, 1'b1, 14, n);
        final_report;
    end
endmodule
